// file: verilog/pgs_selector.sv
/*
 pgs_selector: priority selector of the active parameter group, with
 override mode, remote and local change requests and failure events.
 assumes: all inputs but rst_b synchronous to clk; the consumer of active_group reloads
 its parameter set when told by load_defaults.
*/
// Behaviour
// R1: up to eight groups; exactly one group active at any time.
// R2: after reset group one is active; selector idles while only group one used.
// R3: with two or more groups used, requests decide the active group.
// R4: override enable set: automatic requests ignored, operator choice applies.
// R5: each request input works as a pulse or as a static level.
// R6: group one highest priority, group eight lowest; highest simultaneous request wins.
// R7: two static levels at once: the higher-priority group becomes active.
// R8: a pulse-selected group stays active until another group is requested.
// R9: forced change only to an enabled group and with override enable set.
// R10: on override release, present static levels take control at once.
// R11: active group readable as one of eight values, group one by default.
// R12: override parameter: none or group one to eight, acts as pulse request.
// R13: after override release without requests the last group stays active.
// R14: override enable defaults off, must be set for remote or local change.
// R15: used-groups setting enables groups; newly enabled groups load defaults.
// R16: remote change: none or group; refused under higher-priority static request.
// R17: a static request blocks every lower-priority pulse request and remote change.
// R18: time-stamped on/off events for not-configured and lower-priority failures.
// R19: pulse is the rising edge on clk; active group updates within one cycle.
`timescale 1ns/1ps
module pgs_selector
	import pgs_pkg::*;
#(
	parameter int TS_W = 32
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] group_req,
	input wire logic [2:0] used_groups,
	input wire logic override_enable,
	input wire logic [3:0] override_param,
	input wire logic [3:0] local_param,
	input wire logic [3:0] remote_param,
	output logic [2:0] active_group,
	output logic [7:0] active_onehot,
	output logic [1:0] selector_mode,
	output logic [7:0] load_defaults,
	output logic fail_not_config,
	output logic fail_lower_prio,
	output logic fail_force,
	output logic ev_valid,
	output logic [1:0] ev_code,
	output logic ev_on,
	output logic [TS_W-1:0] ev_time
);

	logic rst_meta_q;
	logic rst_sync_q;
	logic rst_sync_b;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign rst_sync_b = rst_sync_q;

	logic [7:0] rise;
	logic [7:0] held;

	pgs_req_edge #(
		.N(PGS_GROUPS)
	) u_req_edge (
		.clk(clk),
		.rst_sync_b(rst_sync_b),
		.level(group_req),
		.rise(rise),
		.held(held)
	);

	pgs_state_e st_q, st_d;
	logic [2:0] act_q, act_d;
	logic [7:0] act_oh_q, act_oh_d;
	logic [7:0] en_prev_q, en_prev_d;
	logic [7:0] load_q, load_d;
	logic [3:0] ovp_prev_q, ovp_prev_d;
	logic [3:0] loc_prev_q, loc_prev_d;
	logic [3:0] rem_prev_q, rem_prev_d;
	logic ovr_prev_q, ovr_prev_d;
	logic [3:0] flag_q, flag_d;
	logic [3:0] rep_q, rep_d;
	logic ev_valid_q, ev_valid_d;
	logic [1:0] ev_code_q, ev_code_d;
	logic ev_on_q, ev_on_d;
	logic [TS_W-1:0] ev_time_q, ev_time_d;
	logic [TS_W-1:0] ts_q, ts_d;

	// request decode
	logic [7:0] en;
	logic top_v;
	logic [2:0] top;
	logic [7:0] block;
	logic [7:0] cand;
	logic win_v;
	logic [2:0] win;
	logic p_new, l_new, r_new;
	logic f_req, f_remote, f_ok;
	logic [3:0] f_tgt;
	logic [2:0] f_idx;
	logic r_blocked;

	always_comb begin
		en = pgs_used_mask(used_groups);
		top_v = |(held & en);
		top = pgs_first_set(held & en);
		block = top_v ? pgs_below_mask(top) : 8'h00; // see R17
		cand = (rise & en & ~block) | (top_v ? pgs_onehot(top) : 8'h00); // see R5
		win_v = |cand;
		win = pgs_first_set(cand); // see R6
		// a fresh override enable also replays a standing forced group
		p_new = pgs_param_valid(override_param) &&
			((override_param != ovp_prev_q) || (override_enable && !ovr_prev_q));
		l_new = pgs_param_valid(local_param) && (local_param != loc_prev_q);
		r_new = pgs_param_valid(remote_param) && (remote_param != rem_prev_q);
		f_req = p_new || l_new || r_new;
		f_remote = !p_new && !l_new && r_new;
		f_tgt = p_new ? override_param : (l_new ? local_param : remote_param);
		f_idx = 3'(f_tgt - 4'h1);
		r_blocked = f_remote && top_v && (top < f_idx); // see R16
		f_ok = f_req && override_enable && en[f_idx] && !r_blocked; // see R9
	end

	// mode and active group
	always_comb begin
		logic [3:0] set_fl;
		logic [3:0] clr_fl;
		set_fl = 4'h0;
		clr_fl = 4'h0;
		act_d = act_q; // see R8, R13
		if (used_groups == PGS_RST_USED) begin
			st_d = PGS_ST_IDLE; // see R2
		end else if (override_enable) begin
			st_d = PGS_ST_FORCE;
		end else begin
			st_d = PGS_ST_AUTO; // see R3
		end
		case (st_d)
			PGS_ST_IDLE: begin
				act_d = PGS_RST_GROUP; // see R2
			end
			PGS_ST_AUTO: begin
				// static levels re-enter here the cycle the override drops
				if (win_v) begin
					act_d = win; // see R7, R10, R19
					clr_fl[1:0] = 2'b11;
				end else if (!en[act_q]) begin
					act_d = PGS_RST_GROUP;
				end
				if (|(rise & ~en)) begin
					set_fl[PGS_EV_NOT_CONFIG] = 1'b1; // see R18
				end
				if (|(rise & en & ~(win_v ? pgs_onehot(win) : 8'h00))) begin
					set_fl[PGS_EV_LOWER_PRIO] = 1'b1; // see R18
				end
				if (f_req) begin
					set_fl[PGS_EV_FORCE_FAIL] = 1'b1; // see R14
				end
			end
			PGS_ST_FORCE: begin
				// group_req pulses are not looked at here; held levels only refuse remote changes
				clr_fl[PGS_EV_FORCE_FAIL] = 1'b1;
				if (f_ok) begin
					act_d = f_idx; // see R4, R12
					clr_fl[1:0] = 2'b11;
				end else if (!en[act_q]) begin
					act_d = PGS_RST_GROUP;
				end
				if (f_req && !en[f_idx]) begin
					set_fl[PGS_EV_NOT_CONFIG] = 1'b1; // see R9, R18
				end
				if (r_blocked) begin
					set_fl[PGS_EV_LOWER_PRIO] = 1'b1; // see R16
				end
			end
			default: begin
				act_d = PGS_RST_GROUP;
			end
		endcase
		act_oh_d = pgs_onehot(act_d); // see R1, R11
		// set wins over clear so no failure is lost
		flag_d = (flag_q & ~clr_fl) | set_fl;
		flag_d[PGS_EV_OVERRIDE] = override_enable;
		en_prev_d = en;
		load_d = en & ~en_prev_q; // see R15
		ovp_prev_d = override_param;
		loc_prev_d = local_param;
		rem_prev_d = remote_param;
		ovr_prev_d = override_enable;
	end

	// event reporter: one change per cycle, the rest wait their turn
	always_comb begin
		logic [3:0] diff;
		logic [2:0] pick;
		diff = flag_q ^ rep_q;
		pick = pgs_first_set({4'h0, diff});
		ts_d = ts_q + 1'b1;
		rep_d = rep_q;
		ev_valid_d = 1'b0;
		ev_code_d = ev_code_q;
		ev_on_d = ev_on_q;
		ev_time_d = ev_time_q;
		if (|diff) begin
			ev_valid_d = 1'b1; // see R18
			ev_code_d = pick[1:0];
			ev_on_d = flag_q[pick[1:0]];
			ev_time_d = ts_q;
			rep_d = rep_q ^ 4'(pgs_onehot(pick));
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			st_q <= PGS_ST_IDLE;
			act_q <= PGS_RST_GROUP;
			act_oh_q <= PGS_RST_ONEHOT;
			en_prev_q <= PGS_RST_ONEHOT;
			load_q <= 8'h00;
			ovp_prev_q <= PGS_PARAM_NONE;
			loc_prev_q <= PGS_PARAM_NONE;
			rem_prev_q <= PGS_PARAM_NONE;
			ovr_prev_q <= 1'b0;
			flag_q <= 4'h0;
			rep_q <= 4'h0;
			ev_valid_q <= 1'b0;
			ev_code_q <= 2'h0;
			ev_on_q <= 1'b0;
			ev_time_q <= '0;
			ts_q <= '0;
		end else begin
			st_q <= st_d;
			act_q <= act_d;
			act_oh_q <= act_oh_d;
			en_prev_q <= en_prev_d;
			load_q <= load_d;
			ovp_prev_q <= ovp_prev_d;
			loc_prev_q <= loc_prev_d;
			rem_prev_q <= rem_prev_d;
			ovr_prev_q <= ovr_prev_d;
			flag_q <= flag_d;
			rep_q <= rep_d;
			ev_valid_q <= ev_valid_d;
			ev_code_q <= ev_code_d;
			ev_on_q <= ev_on_d;
			ev_time_q <= ev_time_d;
			ts_q <= ts_d;
		end
	end

	assign active_group = act_q;
	assign active_onehot = act_oh_q;
	assign selector_mode = st_q;
	assign load_defaults = load_q;
	assign fail_not_config = flag_q[PGS_EV_NOT_CONFIG];
	assign fail_lower_prio = flag_q[PGS_EV_LOWER_PRIO];
	assign fail_force = flag_q[PGS_EV_FORCE_FAIL];
	assign ev_valid = ev_valid_q;
	assign ev_code = ev_code_q;
	assign ev_on = ev_on_q;
	assign ev_time = ev_time_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_b);

	property p_one_active;
		$onehot(active_onehot) && active_onehot[active_group];
	endproperty
	a_one_active: assert property (p_one_active) else $error("active group not one-hot"); // see R1

	property p_idle_group_one;
		(used_groups == PGS_RST_USED) |=> (active_group == PGS_RST_GROUP) && (st_q == PGS_ST_IDLE);
	endproperty
	a_idle_group_one: assert property (p_idle_group_one) else $error("idle but not group one"); // see R2

	property p_force_holds;
		(st_d == PGS_ST_FORCE) && !f_ok && en[act_q] |=> $stable(active_group);
	endproperty
	a_force_holds: assert property (p_force_holds) else $error("group moved in override"); // see R4

	property p_top_pulse;
		(st_d == PGS_ST_AUTO) && rise[0] && en[0] |=> (active_group == 3'h0);
	endproperty
	a_top_pulse: assert property (p_top_pulse) else $error("group one pulse lost"); // see R6

	property p_pulse_hold;
		(st_d == PGS_ST_AUTO) && !win_v && en[act_q] |=> $stable(active_group);
	endproperty
	a_pulse_hold: assert property (p_pulse_hold) else $error("group dropped without request"); // see R8

	property p_force_take;
		// idle mode outranks the override, so only a forced cycle is judged
		f_ok && (st_d == PGS_ST_FORCE) |=> (active_group == $past(f_idx)) && (st_q == PGS_ST_FORCE);
	endproperty
	a_force_take: assert property (p_force_take) else $error("forced group not applied"); // see R9

	sequence s_release;
		ovr_prev_q && !override_enable && (used_groups != PGS_RST_USED) && top_v;
	endsequence
	property p_release;
		s_release |=> (active_group <= $past(top)) && (st_q == PGS_ST_AUTO);
	endproperty
	a_release: assert property (p_release) else $error("static level ignored on release"); // see R10

	property p_static_block;
		(st_d == PGS_ST_AUTO) && top_v |=> (active_group <= $past(top));
	endproperty
	a_static_block: assert property (p_static_block) else $error("lower group beat static"); // see R17

	property p_remote_refuse;
		r_blocked && (st_d == PGS_ST_FORCE) && en[act_q] |=> fail_lower_prio && $stable(active_group);
	endproperty
	a_remote_refuse: assert property (p_remote_refuse) else $error("remote not refused"); // see R16

	property p_new_defaults;
		(used_groups > $past(used_groups)) |=> (load_defaults != 8'h00);
	endproperty
	a_new_defaults: assert property (p_new_defaults) else $error("no default load"); // see R15

	sequence s_nc_report;
		ev_valid && ev_on && (ev_code == PGS_EV_NOT_CONFIG);
	endsequence
	property p_nc_event;
		$rose(fail_not_config) |-> ##[1:4] s_nc_report;
	endproperty
	a_nc_event: assert property (p_nc_event) else $error("not-configured event missing"); // see R18

endmodule // pgs_selector

// file: verilog/pgs_pkg.sv
/*
 pgs_pkg: constants, state type and helper functions for the parameter group selector.
 assumes: at most eight groups; group index 0 stands for group one (highest priority).
*/
package pgs_pkg;

	localparam int PGS_GROUPS = 8;
	localparam int PGS_IW = 3;
	localparam int PGS_PW = 4;

	// parameter code: 0 is none, 1..8 name a group, 9..15 are ignored
	localparam logic [3:0] PGS_PARAM_NONE = 4'h0;
	localparam logic [3:0] PGS_PARAM_MAX = 4'h8;

	localparam logic [2:0] PGS_RST_GROUP = 3'h0;
	localparam logic [7:0] PGS_RST_ONEHOT = 8'h01;
	localparam logic [2:0] PGS_RST_USED = 3'h0;

	// event codes, also the bit order of the flag vector
	localparam logic [1:0] PGS_EV_NOT_CONFIG = 2'h0;
	localparam logic [1:0] PGS_EV_LOWER_PRIO = 2'h1;
	localparam logic [1:0] PGS_EV_FORCE_FAIL = 2'h2;
	localparam logic [1:0] PGS_EV_OVERRIDE = 2'h3;

	typedef enum logic [1:0] {
		PGS_ST_IDLE = 2'b00,
		PGS_ST_AUTO = 2'b01,
		PGS_ST_FORCE = 2'b11
	} pgs_state_e;

	function automatic logic [2:0] pgs_first_set(input logic [7:0] v);
		pgs_first_set = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				pgs_first_set = 3'(i);
			end
		end
	endfunction

	function automatic logic [7:0] pgs_onehot(input logic [2:0] idx);
		pgs_onehot = 8'h01 << idx;
	endfunction

	// used setting n enables groups one to n+1
	function automatic logic [7:0] pgs_used_mask(input logic [2:0] n);
		pgs_used_mask = 8'((16'h0002 << n) - 16'h0001);
	endfunction

	// all groups of lower priority than idx
	function automatic logic [7:0] pgs_below_mask(input logic [2:0] idx);
		pgs_below_mask = 8'(16'h00ff << ({1'b0, idx} + 4'h1));
	endfunction

	function automatic logic pgs_param_valid(input logic [3:0] p);
		pgs_param_valid = (p != PGS_PARAM_NONE) && (p <= PGS_PARAM_MAX);
	endfunction

endpackage

// file: verilog/pgs_req_edge.sv
/*
 pgs_req_edge: splits request levels into a first-cycle rise and a held level.
 assumes: levels synchronous to clk; reset already synchronised by the caller.
*/
`timescale 1ns/1ps
module pgs_req_edge
	import pgs_pkg::*;
#(
	parameter int N = PGS_GROUPS
) (
	input wire logic clk,
	input wire logic rst_sync_b,
	input wire logic [N-1:0] level,
	output logic [N-1:0] rise,
	output logic [N-1:0] held
);

	logic [N-1:0] prev_q;
	logic [N-1:0] prev_d;

	always_comb begin
		prev_d = level;
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			prev_q <= '0;
		end else begin
			prev_q <= prev_d;
		end
	end

	// a level seen for a second cycle counts as static
	assign rise = level & ~prev_q;
	assign held = level & prev_q;

endmodule // pgs_req_edge

// file: dv/pgs_req_source.sv
/*
 pgs_req_source: stands in for internal logic, digital inputs, remote and local operator.
 assumes: one clk; the bench calls drive() to move every request field together.
*/
`timescale 1ns/1ps
module pgs_req_source (
	input wire logic clk,
	output logic [7:0] group_req,
	output logic [2:0] used_groups,
	output logic override_enable,
	output logic [3:0] override_param,
	output logic [3:0] local_param,
	output logic [3:0] remote_param
);
	initial begin
		group_req = 8'h00;
		used_groups = 3'h0;
		override_enable = 1'h0;
		override_param = 4'h0;
		local_param = 4'h0;
		remote_param = 4'h0;
	end

	// all fields move at one instant so no half-applied request is seen
	task automatic drive(input logic [7:0] req, input logic [2:0] used, input logic ovr,
		input logic [3:0] op, input logic [3:0] lp, input logic [3:0] rp);
		@(posedge clk);
		#2;
		group_req = req;
		used_groups = used;
		override_enable = ovr;
		override_param = op;
		local_param = lp;
		remote_param = rp;
	endtask
endmodule // pgs_req_source

// file: dv/pgs_selector_test.sv
/*
 pgs_selector_test: directed scenarios for the parameter group selector.
 assumes: pgs_pkg compiled first; pgs_req_source drives every request input.
*/
`timescale 1ns/1ps
module pgs_selector_test;
	import pgs_pkg::*;
	logic clk;
	logic rst_b;
	logic [7:0] group_req;
	logic [2:0] used_groups;
	logic override_enable;
	logic [3:0] override_param;
	logic [3:0] local_param;
	logic [3:0] remote_param;
	logic [2:0] active_group;
	logic [7:0] active_onehot;
	logic [1:0] selector_mode;
	logic [7:0] load_defaults;
	logic fail_not_config;
	logic fail_lower_prio;
	logic fail_force;
	logic ev_valid;
	logic [1:0] ev_code;
	logic ev_on;
	logic [31:0] ev_time;
	int err_count;
	int checks_done;
	int n_edges;

	pgs_req_source u_src (.clk(clk), .group_req(group_req), .used_groups(used_groups),
		.override_enable(override_enable), .override_param(override_param),
		.local_param(local_param), .remote_param(remote_param));

	pgs_selector u_dut (.clk(clk), .rst_b(rst_b), .group_req(group_req),
		.used_groups(used_groups), .override_enable(override_enable),
		.override_param(override_param), .local_param(local_param),
		.remote_param(remote_param), .active_group(active_group),
		.active_onehot(active_onehot), .selector_mode(selector_mode),
		.load_defaults(load_defaults), .fail_not_config(fail_not_config),
		.fail_lower_prio(fail_lower_prio), .fail_force(fail_force), .ev_valid(ev_valid),
		.ev_code(ev_code), .ev_on(ev_on), .ev_time(ev_time));

	// edge count to judge the spacing of event time stamps
	always @(posedge clk) begin
		n_edges <= n_edges + 1;
	end

	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (err_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#3;
	endtask

	task automatic d(input logic [7:0] r, input logic [2:0] u, input logic o = 1'h0,
		input logic [3:0] op = 4'h0, input logic [3:0] lp = 4'h0, input logic [3:0] rp = 4'h0);
		u_src.drive(r, u, o, op, lp, rp);
		#1;
	endtask

	// bounded hunt; events may queue behind earlier ones
	task automatic expect_event(input logic [1:0] code, input logic on,
		output logic [31:0] stamp);
		logic hit;
		hit = 1'h0;
		stamp = '0;
		for (int n = 0; n < 16 && !hit; n++) begin
			cyc(1);
			hit = (ev_valid === 1'h1) && (ev_code === code);
		end
		if (!hit) begin
			err_count++;
			tally_and_finish();
		end else begin
			stamp = ev_time;
			check(8'(ev_on), 8'(on));
		end
	endtask

	task automatic t_reset();
		check(8'(active_group), 8'h00);
		check(active_onehot, 8'h01);
		check(8'(selector_mode), 8'h00);
		check(8'({fail_not_config, fail_lower_prio, fail_force}), 8'h00);
	endtask

	task automatic t_idle();
		d(8'h04, 3'h0);
		d(8'h00, 3'h0);
		check(8'(active_group), 8'h00);
	endtask

	task automatic t_enable();
		logic [7:0] seen;
		seen = 8'h00;
		d(8'h00, 3'h7);
		for (int n = 0; n < 4; n++) begin
			cyc(1);
			seen = seen | load_defaults;
		end
		check(seen, 8'hfe);
		check(8'(selector_mode), 8'h01);
	endtask

	task automatic t_pulse();
		d(8'h04, 3'h7);
		d(8'h00, 3'h7);
		check(8'(active_group), 8'h02);
		check(active_onehot, 8'h04);
		cyc(3);
		check(8'(active_group), 8'h02);
		d(8'h18, 3'h7);
		d(8'h00, 3'h7);
		check(8'(active_group), 8'h03);
		d(8'h09, 3'h7);
		d(8'h00, 3'h7);
		check(8'(active_group), 8'h00);
	endtask

	task automatic t_static();
		d(8'h22, 3'h7);
		cyc(2);
		check(8'(active_group), 8'h01);
		d(8'h62, 3'h7);
		d(8'h22, 3'h7);
		// the held level counts as a win each cycle, so the flag shows for one cycle
		check(8'(fail_lower_prio), 8'h01);
		check(8'(active_group), 8'h01);
		cyc(1);
		check(8'(active_group), 8'h01);
		d(8'h22, 3'h7, 1'h0, 4'h0, 4'h0, 4'h7);
		cyc(1);
		check(8'(fail_force), 8'h01);
		check(8'(active_group), 8'h01);
	endtask

	task automatic t_override();
		d(8'h22, 3'h7, 1'h1, 4'h5);
		cyc(1);
		check(8'(selector_mode), 8'h03);
		check(8'(active_group), 8'h04);
		d(8'h23, 3'h7, 1'h1, 4'h5);
		d(8'h22, 3'h7, 1'h1, 4'h5);
		cyc(1);
		check(8'(active_group), 8'h04);
		d(8'h22, 3'h7, 1'h1, 4'h5, 4'h3);
		cyc(1);
		check(8'(active_group), 8'h02);
		d(8'h22, 3'h7, 1'h1, 4'h5, 4'h3, 4'h7);
		cyc(1);
		check(8'(fail_lower_prio), 8'h01);
		check(8'(active_group), 8'h02);
		d(8'h22, 3'h7, 1'h0, 4'h5, 4'h3);
		cyc(1);
		check(8'(active_group), 8'h01);
	endtask

	task automatic t_release();
		d(8'h00, 3'h7, 1'h1, 4'h6, 4'h3);
		cyc(1);
		check(8'(active_group), 8'h05);
		d(8'h00, 3'h7, 1'h0, 4'h6, 4'h3);
		cyc(3);
		check(8'(active_group), 8'h05);
		check(8'(selector_mode), 8'h01);
	endtask

	task automatic t_not_config();
		logic [31:0] t_on;
		logic [31:0] t_off;
		int e_on;
		int e_off;
		d(8'h00, 3'h2);
		cyc(1);
		check(8'(active_group), 8'h00);
		d(8'h20, 3'h2);
		d(8'h00, 3'h2);
		e_on = n_edges;
		check(8'(fail_not_config), 8'h01);
		check(8'(active_group), 8'h00);
		expect_event(PGS_EV_NOT_CONFIG, 1'h1, t_on);
		d(8'h02, 3'h2);
		d(8'h00, 3'h2);
		e_off = n_edges;
		check(8'(fail_not_config), 8'h00);
		check(8'(active_group), 8'h01);
		expect_event(PGS_EV_NOT_CONFIG, 1'h0, t_off);
		// stamps must be as far apart as the flag changes were
		check(8'(t_off - t_on), 8'(e_off - e_on));
	endtask

	initial begin
		err_count = 0;
		checks_done = 0;
		rst_b = 1'h0;
		repeat (16) @(posedge clk);
		#2;
		rst_b = 1'h1;
		cyc(3);
		t_reset();
		t_idle();
		t_enable();
		t_pulse();
		t_static();
		t_override();
		t_release();
		t_not_config();
		tally_and_finish();
	end
endmodule // pgs_selector_test
